// ==== logic/pulse_pattern_unit.sv ====
// Pulse pattern unit: per-group trigger selection and output mode, Wishbone slave
`timescale 1ns/1ps
`include "pulse_pattern_map.svh"

module pulse_pattern_unit
   import pulse_pattern_pkg::*;
#(
   parameter int GROUPS    = 4,
   parameter int GRP_WIDTH = 4
) (
   input  wire logic        clk_sys_in,    // System clock, 50 MHz
   input  wire logic        nrst_in,       // Async reset, active low
   input  wire logic        wb_cyc_in,     // Wishbone cycle
   input  wire logic        wb_stb_in,     // Wishbone strobe
   input  wire logic        wb_we_in,      // Wishbone write enable
   input  wire logic [7:0]  wb_adr_in,     // Wishbone byte address
   input  wire logic [3:0]  wb_sel_in,     // Wishbone byte selects
   input  wire logic [31:0] wb_dat_in,     // Wishbone write data
   output wire logic [31:0] wb_dat_out,    // Wishbone read data
   output wire logic        wb_ack_out,    // Wishbone acknowledge
   input  wire timer_evt_t  timer_evt_in,  // Compare-match A/B pulses per channel
   output wire logic [15:0] pulse_out,     // Pulse output pins
   output wire logic [15:0] pulse_oe_out   // Pulse output enables
);

   localparam int NBITS = GROUPS * GRP_WIDTH;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake

   bus_state_t  state_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        req;
   logic        wr_go;
   logic        hit_trig;
   logic        hit_mode;
   logic        hit_next;
   logic        hit_en;
   logic        hit_od;

   assign req      = wb_cyc_in & wb_stb_in;
   assign hit_trig = wb_adr_in == `TRIG_SEL_OFS;
   assign hit_mode = wb_adr_in == `OUT_MODE_OFS;
   assign hit_next = wb_adr_in == `NEXT_DATA_OFS;
   assign hit_en   = wb_adr_in == `NEXT_EN_OFS;
   assign hit_od   = wb_adr_in == `OUT_DATA_OFS;

   // Write lands on the same edge at which the master sees ack
   assign wr_go = (state_q == BUS_ACK) & req & wb_we_in;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= BUS_IDLE;
      end else begin
         unique case (state_q)
            BUS_IDLE: begin
               if (req) begin
                  state_q <= BUS_ACK;
               end
            end
            BUS_ACK: begin
               state_q <= BUS_IDLE;
            end
         endcase
      end
   end

   assign wb_ack_out = (state_q == BUS_ACK);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]       trig_sel_q;
   logic [7:0]       out_mode_q;
   logic [NBITS-1:0] next_data_q;
   logic [NBITS-1:0] next_en_q;
   logic [NBITS-1:0] out_data;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trig_sel_q <= `TRIG_SEL_RST;
      end else if (wr_go && hit_trig && wb_sel_in[0]) begin
         trig_sel_q <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         out_mode_q <= `OUT_MODE_RST;
      end else if (wr_go && hit_mode && wb_sel_in[0]) begin
         out_mode_q <= wb_dat_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         next_data_q <= `NEXT_DATA_RST;
      end else if (wr_go && hit_next) begin
         next_data_q <= merge16(next_data_q, wb_dat_in, wb_sel_in);
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         next_en_q <= `NEXT_EN_RST;
      end else if (wr_go && hit_en) begin
         next_en_q <= merge16(next_en_q, wb_dat_in, wb_sel_in);
      end
   end

   // Read data is captured when the request is first seen; it is stable during ack
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_trig) begin
         rdata_d[7:0] = trig_sel_q;
      end else if (hit_mode) begin
         rdata_d[7:0] = out_mode_q;
      end else if (hit_next) begin
         rdata_d[15:0] = next_data_q;
      end else if (hit_en) begin
         rdata_d[15:0] = next_en_q;
      end else if (hit_od) begin
         rdata_d[15:0] = out_data;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (state_q == BUS_IDLE && req) begin
         rdata_q <= rdata_d;
      end
   end

   assign wb_dat_out = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Group slices

   logic [NBITS-1:0] od_wdata;
   logic [1:0]       od_wr;

   // Output data written a byte lane at a time, two groups per lane
   assign od_wdata = wb_dat_in[15:0];
   assign od_wr    = {2{wr_go & hit_od}} & wb_sel_in[1:0];

   for (genvar g = 0; g < GROUPS; g++) begin : grp
      group_cfg_t cfg;

      always_comb begin
         cfg.trig_sel = trig_sel_q[g*`TRIG_SEL_W +: `TRIG_SEL_W];
         cfg.direct   = out_mode_q[`DIRECT_LSB + g];
         cfg.non_ovl  = out_mode_q[`NON_OVL_LSB + g];
      end

      pulse_group #(
         .WIDTH (GRP_WIDTH)
      ) u_group (
         .clk_sys_in   (clk_sys_in),
         .nrst_in      (nrst_in),
         .cfg_in       (cfg),
         .evt_in       (timer_evt_in),
         .next_data_in (next_data_q[g*GRP_WIDTH +: GRP_WIDTH]),
         .next_en_in   (next_en_q[g*GRP_WIDTH +: GRP_WIDTH]),
         .od_wr_in     (od_wr[g/2]),
         .od_wdata_in  (od_wdata[g*GRP_WIDTH +: GRP_WIDTH]),
         .out_data_out (out_data[g*GRP_WIDTH +: GRP_WIDTH]),
         .pin_out      (pulse_out[g*GRP_WIDTH +: GRP_WIDTH])
      );
   end

   // Output enable is the next-enable bit, so a pin disabled for pulse output takes no transfers
   assign pulse_oe_out = next_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (req && !wb_ack_out |=> wb_ack_out)
      else $error("ack not given one cycle after request");
   trig_write_a: assert property (wr_go && hit_trig && wb_sel_in[0] |=>
      trig_sel_q == $past(wb_dat_in[7:0]))
      else $error("trigger select write lost");
   trig_hold_a: assert property (!(wr_go && hit_trig) |=> $stable(trig_sel_q))
      else $error("trigger select changed without write");
   mode_write_a: assert property (wr_go && hit_mode && wb_sel_in[0] |=>
      out_mode_q == $past(wb_dat_in[7:0]))
      else $error("mode write lost");
   mode_read_a: assert property (req && !wb_ack_out && hit_mode |=>
      wb_ack_out && wb_dat_out == {24'h000000, out_mode_q})
      else $error("mode readback wrong");
   // Group 3 must follow the channel named by bits 7:6, independent of the slice wiring
   group_three_sel_a: assert property (timer_evt_in.cmp_a[trig_sel_q[7:6]] && !od_wr[1] |=>
      out_data[15:12] == (($past(next_data_q[15:12]) & $past(next_en_q[15:12])) |
                          ($past(out_data[15:12]) & ~$past(next_en_q[15:12]))))
      else $error("group 3 selector miswired");

endmodule

// ==== logic/pulse_pattern_map.svh ====
// Register offsets, field positions and reset values of the pulse pattern unit
`ifndef PULSE_PATTERN_MAP_SVH
`define PULSE_PATTERN_MAP_SVH

`define TRIG_SEL_OFS   8'h00
`define OUT_MODE_OFS   8'h04
`define NEXT_DATA_OFS  8'h08
`define NEXT_EN_OFS    8'h0c
`define OUT_DATA_OFS   8'h10

`define TRIG_SEL_RST   8'hff
`define OUT_MODE_RST   8'hf0
`define NEXT_DATA_RST  16'h0000
`define NEXT_EN_RST    16'h0000
`define OUT_DATA_RST   16'h0000
`define PIN_RST        4'h0

`define TRIG_SEL_W     2
`define DIRECT_LSB     4
`define NON_OVL_LSB    0

`endif

// ==== logic/pulse_pattern_pkg.sv ====
// Types shared by the pulse pattern unit and its group slices
package pulse_pattern_pkg;

   typedef struct packed {
      logic [3:0] cmp_a;
      logic [3:0] cmp_b;
   } timer_evt_t;

   typedef struct packed {
      logic [1:0] trig_sel;
      logic       direct;
      logic       non_ovl;
   } group_cfg_t;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage

// ==== logic/pulse_group.sv ====
// One pulse output group: trigger pick, next-data transfer and pin polarity
`timescale 1ns/1ps
`include "pulse_pattern_map.svh"

module pulse_group
   import pulse_pattern_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_sys_in,    // System clock
   input  wire logic             nrst_in,       // Async reset, active low
   input  wire group_cfg_t       cfg_in,        // Trigger, polarity and mode of this group
   input  wire timer_evt_t       evt_in,        // Compare-match pulses of all channels
   input  wire logic [WIDTH-1:0] next_data_in,  // Next-data bits
   input  wire logic [WIDTH-1:0] next_en_in,    // Per-bit transfer enable
   input  wire logic             od_wr_in,      // Software write of output data
   input  wire logic [WIDTH-1:0] od_wdata_in,   // Software output data
   output wire logic [WIDTH-1:0] out_data_out,  // Output data bits
   output wire logic [WIDTH-1:0] pin_out        // Pin levels after polarity
);

   logic [WIDTH-1:0] od_q;
   logic [WIDTH-1:0] od_d;
   logic [WIDTH-1:0] pin_q;
   logic             hit_a;
   logic             hit_b;
   logic             direct;

   assign direct = cfg_in.direct;
   assign hit_a  = evt_in.cmp_a[cfg_in.trig_sel];
   assign hit_b  = cfg_in.non_ovl & evt_in.cmp_b[cfg_in.trig_sel];

   // A timer event transfer is applied on top of a software write landing in the same cycle
   always_comb begin
      od_d = od_q;
      if (od_wr_in) begin
         od_d = od_wdata_in;
      end
      if (hit_a) begin
         od_d = (od_d & ~next_en_in) | (next_data_in & next_en_in);
      end else if (hit_b) begin
         od_d = od_d & ~(next_en_in & ~next_data_in);
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         od_q <= WIDTH'(`OUT_DATA_RST);
      end else begin
         od_q <= od_d;
      end
   end

   // Pin is registered so it never glitches while polarity is rewritten
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_q <= WIDTH'(`PIN_RST);
      end else begin
         pin_q <= direct ? od_d : ~od_d;
      end
   end

   assign out_data_out = od_q;
   assign pin_out      = pin_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   // Expected values start from the data before the event, so a broken transfer shows
   match_a_copy_a: assert property (hit_a |=> out_data_out ==
      (($past(next_data_in) & $past(next_en_in)) |
       (($past(od_wr_in) ? $past(od_wdata_in) : $past(out_data_out)) & ~$past(next_en_in))))
      else $error("compare A did not copy next data");
   match_b_zeros_a: assert property (hit_b && !hit_a |=>
      out_data_out == (($past(od_wr_in) ? $past(od_wdata_in) : $past(out_data_out)) &
                       ~($past(next_en_in) & ~$past(next_data_in))))
      else $error("compare B transfer wrong");
   normal_ignores_b_a: assert property (!cfg_in.non_ovl && !hit_a && !od_wr_in |=> $stable(out_data_out))
      else $error("output changed without compare A in normal mode");
   b_clears_only_a: assert property (hit_b && !hit_a && !od_wr_in |=>
      ((out_data_out & ~$past(out_data_out)) == '0))
      else $error("compare B set a bit");
   pin_polarity_a: assert property (##1 pin_out ==
      ($past(direct) ? out_data_out : ~out_data_out))
      else $error("pin polarity wrong");

endmodule

// ==== testbench/timer_unit_model.sv ====
// Behavioural timer unit that fires compare-match pulses on request
`timescale 1ns/1ps

module timer_unit_model
   import pulse_pattern_pkg::*;
(
   input  wire logic       clk_sys_in, // System clock
   input  wire logic       nrst_in,    // Async reset, active low
   input  wire logic       go_in,      // Fire request
   input  wire logic [3:0] a_in,       // Channels raising compare A
   input  wire logic [3:0] b_in,       // Channels raising compare B
   input  wire logic [3:0] wait_in,    // Extra cycles before firing
   output timer_evt_t      evt_out     // One-cycle compare pulses
);
   logic       pend_q;
   logic [3:0] cnt_q;
   logic [7:0] ab_q;

   // A late answer shows the unit does not rely on a fixed event latency
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pend_q  <= 1'b0;
         cnt_q   <= 4'h0;
         ab_q    <= 8'h00;
         evt_out <= '0;
      end else begin
         evt_out <= '0;
         if (go_in) begin
            pend_q <= 1'b1;
            cnt_q  <= wait_in;
            ab_q   <= {a_in, b_in};
         end else if (pend_q && cnt_q == 4'h0) begin
            evt_out <= ab_q;
            pend_q  <= 1'b0;
         end else if (pend_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the pulse pattern unit
`timescale 1ns/1ps
`include "pulse_pattern_map.svh"

module tb_top;
   import pulse_pattern_pkg::*;
   typedef struct packed {
      logic [7:0]  trig;
      logic [7:0]  mode;
      logic [15:0] od;
      logic [3:0]  a;
      logic [3:0]  b;
      logic [15:0] pin;
   } row_t;
   logic        clk_sys_in, nrst_in, cyc, stb, we, go, ack;
   logic [7:0]  adr;
   logic [3:0]  sel, fa, fb, fw;
   logic [31:0] wdat, rbus, rd;
   logic [15:0] pins, oe;
   timer_evt_t  evt;
   int          err_total, cmp_count, cyc_cnt;
   // Next data is 5a3c with every bit enabled
   row_t rows [9] = '{
      '{8'hff, 8'hf0, 16'h0000, 4'h8, 4'h0, 16'h5a3c},
      '{8'h1b, 8'hf0, 16'h0000, 4'h1, 4'h0, 16'h5000},
      '{8'h1b, 8'hf0, 16'h0000, 4'h6, 4'h0, 16'h0a30},
      '{8'hff, 8'h50, 16'h0000, 4'h8, 4'h0, 16'haacc},
      '{8'hff, 8'hf0, 16'h0000, 4'h0, 4'h8, 16'h0000},
      '{8'hff, 8'hf5, 16'hffff, 4'h0, 4'h8, 16'hfafc},
      '{8'hff, 8'hff, 16'h0000, 4'h8, 4'h0, 16'h5a3c},
      '{8'hff, 8'hff, 16'h0000, 4'h8, 4'h8, 16'h5a3c},
      '{8'hff, 8'hf0, 16'h1234, 4'h7, 4'h0, 16'h1234}};

   pulse_pattern_unit uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rbus),
      .wb_ack_out(ack), .timer_evt_in(evt), .pulse_out(pins), .pulse_oe_out(oe));
   timer_unit_model tmr (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .go_in(go), .a_in(fa), .b_in(fb),
      .wait_in(fw), .evt_out(evt));

   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 2000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; the request is held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clk_sys_in); while (ack !== 1'b1);
      rd = rbus;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic fire(input logic [3:0] a, input logic [3:0] b, input logic [3:0] w);
      @(posedge clk_sys_in);
      go <= 1'b1;
      fa <= a;
      fb <= b;
      fw <= w;
      @(posedge clk_sys_in);
      go <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
   endtask

   initial begin
      {nrst_in, cyc, stb, we, go, adr, sel, fa, fb, fw, wdat} = '0;
      {err_total, cmp_count, cyc_cnt} = '0;
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      chk(32'(pins), 32'h00000000);
      chk(32'(oe), 32'h00000000);
      wb(1'b0, `TRIG_SEL_OFS, 32'h0, 4'h1);
      chk(rd, 32'h000000ff);
      wb(1'b0, `OUT_MODE_OFS, 32'h0, 4'h1);
      chk(rd, 32'h000000f0);
      wb(1'b1, `NEXT_DATA_OFS, 32'h00005a3c, 4'h3);
      wb(1'b1, `NEXT_EN_OFS, 32'h0000ffff, 4'h3);
      wb(1'b0, `NEXT_DATA_OFS, 32'h0, 4'h3);
      chk(rd, 32'h00005a3c);
      chk(32'(oe), 32'h0000ffff);
      $display("reset test done");
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, `TRIG_SEL_OFS, 32'(rows[i].trig), 4'h1);
         wb(1'b1, `OUT_MODE_OFS, 32'(rows[i].mode), 4'h1);
         wb(1'b1, `OUT_DATA_OFS, 32'(rows[i].od), 4'h3);
         fire(rows[i].a, rows[i].b, i[0] ? 4'h3 : 4'h0);
         chk(32'(pins), 32'(rows[i].pin));
         $display("row %0d test done", i);
      end
      wb(1'b1, `TRIG_SEL_OFS, 32'h000000a5, 4'h1);
      wb(1'b1, `OUT_MODE_OFS, 32'h0000003c, 4'h1);
      // Polarity change alone, no trigger, must reach the pins
      repeat (2) @(posedge clk_sys_in);
      chk(32'(pins), 32'h0000ed34);
      wb(1'b0, `OUT_DATA_OFS, 32'h0, 4'h3);
      chk(rd, 32'h00001234);
      wb(1'b0, `OUT_MODE_OFS, 32'h0, 4'h1);
      chk(rd, 32'h0000003c);
      wb(1'b1, 8'hfc, 32'hffffffff, 4'hf);
      wb(1'b0, 8'hfc, 32'h0, 4'hf);
      chk(rd, 32'h00000000);
      wb(1'b0, `TRIG_SEL_OFS, 32'h0, 4'h1);
      chk(rd, 32'h000000a5);
      $display("register test done");
      // Reset in mid-run, then only the enabled next-data bits may transfer
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      chk(32'(pins), 32'h00000000);
      wb(1'b0, `TRIG_SEL_OFS, 32'h0, 4'h1);
      chk(rd, 32'h000000ff);
      wb(1'b0, `OUT_MODE_OFS, 32'h0, 4'h1);
      chk(rd, 32'h000000f0);
      wb(1'b1, `NEXT_DATA_OFS, 32'h00005a3c, 4'h3);
      wb(1'b1, `NEXT_EN_OFS, 32'h00000f0f, 4'h3);
      fire(4'h8, 4'h0, 4'h0);
      chk(32'(pins), 32'h00000a0c);
      chk(32'(oe), 32'h00000f0f);
      wb(1'b0, `OUT_DATA_OFS, 32'h0, 4'h3);
      chk(rd, 32'h00000a0c);
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule
